// File: common/cipc_defines.svh
/*
 * Register offsets, field positions and reset values of the CAN interrupt
 * and pin control block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word a register.
 */
`ifndef CIPC_DEFINES_SVH
`define CIPC_DEFINES_SVH

`define CIPC_OFS_PIN_CTRL 4'h0
`define CIPC_OFS_FLAGS 4'h4
`define CIPC_OFS_ENABLES 4'h8
`define CIPC_OFS_PRIOS 4'hC

`define CIPC_BIT_DRIVE_HIGH 5
`define CIPC_BIT_CAP_ROUTE 4
`define CIPC_BIT_INVALID 7
`define CIPC_BIT_WAKE 6
`define CIPC_BIT_ERROR 5
`define CIPC_BIT_TX2 4
`define CIPC_BIT_TX1 3
`define CIPC_BIT_TX0 2
`define CIPC_BIT_RX1 1
`define CIPC_BIT_RX0 0

`define CIPC_PIN_CTRL_MASK 8'h30
`define CIPC_FLAGS_RST 8'h00
`define CIPC_ENABLES_RST 8'h00
`define CIPC_PRIOS_RST 8'hFF
`define CIPC_MODE12_KEEP 8'hF3
`define CIPC_MODE1_KEEP 8'hF2

`endif

// File: common/cipc_pkg.sv
/*
 * Types of the CAN interrupt and pin control block.
 * Assumes nothing beyond the defines header.
 */
package cipc_pkg;

	typedef enum logic [1:0] {
		CIPC_MODE0,
		CIPC_MODE1,
		CIPC_MODE2,
		CIPC_MODE_RSVD
	} cipc_mode_t;

	// Engine event pulses, one cycle each.
	typedef struct packed {
		logic invalid_msg;
		logic bus_wake;
		logic bus_error;
		logic [2:0] tx_done;
		logic [1:0] rx_full;
		logic watermark;
	} cipc_events_t;

	typedef struct packed {
		logic [7:0] pin_ctrl;
		logic [7:0] flags;
		logic [7:0] enables;
		logic [7:0] prios;
		logic [31:0] rdata;
		logic rvalid;
		logic waitreq;
		logic irq_high;
		logic irq_low;
		logic tx_pin;
		logic tx_oe;
		logic cap_in;
	} cipc_state_t;

endpackage : cipc_pkg

// File: rtl/cipc_core.sv
/*
 * CAN interrupt flag, enable and priority logic with transmit pin drive
 * and capture routing, behind an Avalon-MM slave with waitrequest.
 * Assumes event pulses from the CAN engine on the same clock, and
 * external pins that need synchronising.
 */
// Decided for this implementation: the Avalon-MM register port and the address map.
// Summary of operation
// RULE1: Drive-high bit 1 drives transmit pin high when recessive, else float.
// RULE2: Capture bit 1 routes receive signal to capture unit, else pin.
// RULE3: Invalid message on bus sets invalid-message flag.
// RULE4: Bus activity sets wake flag; zero without activity.
// RULE5: Any engine error source sets error flag.
// RULE6: Mode 0: transmit buffer 2 done sets flag bit 4.
// RULE7: Modes 1,2: any transmit buffer done sets flag bit 4.
// RULE8: Mode 0: transmit buffers 1 and 0 done set bits 3 and 2.
// RULE9: Modes 1,2: bits 3 and 2 of flags, enables, priorities read zero.
// RULE10: Mode 0: receive buffer 1 full sets flag bit 1.
// RULE11: Modes 1,2: any receive buffer full sets flag bit 1.
// RULE12: Mode 0: receive buffer 0 full sets flag bit 0.
// RULE13: Mode 1: bit 0 of all three registers reads zero.
// RULE14: Mode 2: FIFO high watermark sets flag bit 0.
// RULE15: Invalid, wake and error interrupts each gated by own enable.
// RULE16: Mode 0: separate enables gate each buffer interrupt.
// RULE17: Modes 1,2: transmit enable is master gate over per-buffer enables.
// RULE18: Modes 1,2: receive enable is master gate over per-buffer enables.
// RULE19: Mode 2: enable bit 0 gates the watermark interrupt.
// RULE20: Priority 1 selects high level, 0 low; all reset to one.
// RULE21: Per-buffer transmit enable needs the master transmit enable too.
// RULE22: Flag and enable request at chosen level; flags stay until cleared.
module cipc_core
	import cipc_pkg::*;
#(
	parameter int TX_BUFS = 3,
	parameter int RX_BUFS = 2
) (
	input wire logic i_ref_clk, // System clock, 20 MHz.
	input wire logic i_rstn, // Synchronous reset, active low.
	input wire logic i_clk_en, // Freezes all state while low.
	input wire logic [1:0] i_mode, // Controller operating mode.
	input wire cipc_events_t i_events, // Engine event pulses.
	input wire logic [TX_BUFS-1:0] i_per_tx_buffer_enables, // Mode 1,2.
	input wire logic [RX_BUFS-1:0] i_per_buffer_enables, // Mode 1,2.
	input wire logic i_tx_bit, // Engine transmit bit, 0 is dominant.
	input wire logic i_rx_msg, // Message receive signal from engine.
	input wire logic i_capture_pin, // External capture input pin.
	input wire logic [3:0] avs_address, // Byte address.
	input wire logic avs_read, // Read strobe.
	input wire logic avs_write, // Write strobe.
	input wire logic [31:0] avs_writedata, // Write data.
	input wire logic [3:0] avs_byteenable, // Byte enables.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Wait request.
	output logic o_irq_high, // High-priority interrupt request.
	output logic o_irq_low, // Low-priority interrupt request.
	output logic o_bus_transmit_pin, // Transmit pin output value.
	output logic o_bus_transmit_pin_oe, // Transmit pin output enable.
	output logic o_capture_compare_unit // Input to the capture unit.
);
`include "cipc_defines.svh"

	cipc_state_t st_reg;
	cipc_state_t st_next;
	logic [1:0] cap_sync_reg;

	// ====================================================================
	// Bit mask of the bits that the current mode keeps; its zero bits are forced to zero.
	function automatic logic [7:0] keep_mask(input logic [1:0] mode);
		logic [7:0] m;
		m = 8'hFF;
		if (mode == CIPC_MODE1) begin
			m = `CIPC_MODE1_KEEP; // [RULE9] [RULE13]
		end else if (mode != CIPC_MODE0) begin
			m = `CIPC_MODE12_KEEP; // [RULE9]
		end
		return m;
	endfunction : keep_mask

	// ====================================================================
	// Pin synchroniser for the external capture input.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			cap_sync_reg <= 2'h0;
		end else if (i_clk_en) begin
			cap_sync_reg <= {cap_sync_reg[0], i_capture_pin};
		end
	end

	// ====================================================================
	// Next-state logic.
	logic [7:0] kmask;
	logic [7:0] set_bits;
	logic [7:0] wmask;
	logic [7:0] gated;
	logic tx_any;
	logic rx_any;
	logic hit;
	logic is_mode0;

	always_comb begin
		st_next = st_reg;
		kmask = keep_mask(i_mode);
		is_mode0 = (i_mode == CIPC_MODE0);
		// Per-buffer enables narrow which done events count, with master.
		tx_any = |(i_events.tx_done & i_per_tx_buffer_enables); // [RULE21]
		rx_any = |(i_events.rx_full & i_per_buffer_enables);
		set_bits = 8'h00;
		set_bits[`CIPC_BIT_INVALID] = i_events.invalid_msg; // [RULE3]
		set_bits[`CIPC_BIT_WAKE] = i_events.bus_wake; // [RULE4]
		set_bits[`CIPC_BIT_ERROR] = i_events.bus_error; // [RULE5]
		if (is_mode0) begin
			set_bits[`CIPC_BIT_TX2] = i_events.tx_done[2]; // [RULE6]
			set_bits[`CIPC_BIT_TX1] = i_events.tx_done[1]; // [RULE8]
			set_bits[`CIPC_BIT_TX0] = i_events.tx_done[0]; // [RULE8]
			set_bits[`CIPC_BIT_RX1] = i_events.rx_full[1]; // [RULE10]
			set_bits[`CIPC_BIT_RX0] = i_events.rx_full[0]; // [RULE12]
		end else begin
			set_bits[`CIPC_BIT_TX2] = tx_any; // [RULE7] [RULE17]
			set_bits[`CIPC_BIT_RX1] = rx_any; // [RULE11] [RULE18]
			set_bits[`CIPC_BIT_RX0] = i_events.watermark; // [RULE14]
		end
		wmask = 8'h00;
		hit = 1'b0;
		st_next.rvalid = 1'b0;
		st_next.waitreq = 1'b1;
		// One wait cycle, then the access completes with waitrequest low.
		if ((avs_read || avs_write) && st_reg.waitreq) begin
			st_next.waitreq = 1'b0;
			st_next.rdata = 32'h0000_0000;
			hit = 1'b1;
			unique case (avs_address)
				`CIPC_OFS_PIN_CTRL: st_next.rdata[7:0] = st_reg.pin_ctrl;
				`CIPC_OFS_FLAGS: st_next.rdata[7:0] = st_reg.flags & kmask;
				`CIPC_OFS_ENABLES: st_next.rdata[7:0] = st_reg.enables & kmask;
				`CIPC_OFS_PRIOS: st_next.rdata[7:0] = st_reg.prios & kmask;
				default: hit = 1'b0;
			endcase
		end
		if (avs_write && !st_reg.waitreq && avs_byteenable[0]) begin
			wmask = 8'hFF;
		end
		if (avs_write && !st_reg.waitreq) begin
			st_next.waitreq = 1'b1;
			st_next.rdata = 32'h0000_0000;
		end
		if (avs_read && !st_reg.waitreq) begin
			st_next.waitreq = 1'b1;
		end
		if (wmask != 8'h00) begin
			unique case (avs_address)
				`CIPC_OFS_PIN_CTRL:
					st_next.pin_ctrl = avs_writedata[7:0] & `CIPC_PIN_CTRL_MASK;
				`CIPC_OFS_ENABLES: st_next.enables = avs_writedata[7:0];
				`CIPC_OFS_PRIOS: st_next.prios = avs_writedata[7:0];
				default: ;
			endcase
		end
		// Software writes flags; a same-cycle event wins over its clear.
		if (wmask != 8'h00 && avs_address == `CIPC_OFS_FLAGS) begin
			st_next.flags = avs_writedata[7:0] | set_bits; // [RULE22]
		end else begin
			st_next.flags = st_reg.flags | set_bits; // [RULE22]
		end
		st_next.flags = st_next.flags & kmask;
		gated = st_reg.flags & st_reg.enables & kmask; // [RULE15] [RULE16] [RULE19]
		st_next.irq_high = |(gated & st_reg.prios); // [RULE20]
		st_next.irq_low = |(gated & ~st_reg.prios); // [RULE20]
		st_next.tx_pin = i_tx_bit;
		// Recessive is driven high only with the drive-high bit.
		st_next.tx_oe = !i_tx_bit ||
			st_reg.pin_ctrl[`CIPC_BIT_DRIVE_HIGH]; // [RULE1]
		st_next.cap_in = st_reg.pin_ctrl[`CIPC_BIT_CAP_ROUTE] ?
			i_rx_msg : cap_sync_reg[1]; // [RULE2]
		if (hit) begin
			st_next.rvalid = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_reg <= '{pin_ctrl: 8'h00, flags: `CIPC_FLAGS_RST,
				enables: `CIPC_ENABLES_RST, prios: `CIPC_PRIOS_RST,
				rdata: 32'h0000_0000, rvalid: 1'b0, waitreq: 1'b1,
				irq_high: 1'b0, irq_low: 1'b0, tx_pin: 1'b1,
				tx_oe: 1'b0, cap_in: 1'b0};
		end else if (i_clk_en) begin
			st_reg <= st_next;
		end
	end

	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitreq;
	assign o_irq_high = st_reg.irq_high;
	assign o_irq_low = st_reg.irq_low;
	assign o_bus_transmit_pin = st_reg.tx_pin;
	assign o_bus_transmit_pin_oe = st_reg.tx_oe;
	assign o_capture_compare_unit = st_reg.cap_in;

	// ====================================================================
	// Checks.
	sequence s_flag_on(int b);
		st_reg.flags[b] && st_reg.enables[b];
	endsequence

	sequence s_high_sel;
		i_clk_en && st_reg.prios[7] && i_mode == 2'h0;
	endsequence

	sequence s_low_sel;
		i_clk_en && !st_reg.prios[7];
	endsequence

	property p_drive_on;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && !i_tx_bit) |=> o_bus_transmit_pin_oe;
	endproperty
	a_drive_on: assert property (p_drive_on) // [RULE1]
		else $error("Dominant bit not driven on the pin.");

	property p_capture_pin;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && !st_reg.pin_ctrl[4]) |=>
			o_capture_compare_unit == $past(cap_sync_reg[1]);
	endproperty
	a_capture_pin: assert property (p_capture_pin) // [RULE2]
		else $error("Capture unit not fed by the synchronised pin.");

	property p_error_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_events.bus_error) |=> st_reg.flags[5];
	endproperty
	a_error_set: assert property (p_error_set) // [RULE5]
		else $error("Error flag not set.");

	property p_tx2_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode == 2'h0 && i_events.tx_done[2]) |=>
			st_reg.flags[4];
	endproperty
	a_tx2_set: assert property (p_tx2_set) // [RULE6]
		else $error("Transmit buffer 2 flag not set.");

	property p_tx_any_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode != 2'h0 &&
			|(i_events.tx_done & i_per_tx_buffer_enables)) |=>
			st_reg.flags[4];
	endproperty
	a_tx_any_set: assert property (p_tx_any_set) // [RULE7]
		else $error("Any-transmit flag not set.");

	property p_tx1_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode == 2'h0 && i_events.tx_done[1]) |=>
			st_reg.flags[3];
	endproperty
	a_tx1_set: assert property (p_tx1_set) // [RULE8]
		else $error("Transmit buffer 1 flag not set.");

	property p_mode12_zero;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode != 2'h0) |=> st_reg.flags[3:2] == 2'h0;
	endproperty
	a_mode12_zero: assert property (p_mode12_zero) // [RULE9]
		else $error("Transmit buffer 1 and 0 flags set in modes 1 and 2.");

	property p_rx1_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode == 2'h0 && i_events.rx_full[1]) |=>
			st_reg.flags[1];
	endproperty
	a_rx1_set: assert property (p_rx1_set) // [RULE10]
		else $error("Receive buffer 1 flag not set.");

	property p_rx_any_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode != 2'h0 &&
			|(i_events.rx_full & i_per_buffer_enables)) |=>
			st_reg.flags[1];
	endproperty
	a_rx_any_set: assert property (p_rx_any_set) // [RULE11]
		else $error("Any-receive flag not set.");

	property p_rx0_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode == 2'h0 && i_events.rx_full[0]) |=>
			st_reg.flags[0];
	endproperty
	a_rx0_set: assert property (p_rx0_set) // [RULE12]
		else $error("Receive buffer 0 flag not set.");

	property p_watermark_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode == 2'h2 && i_events.watermark) |=>
			st_reg.flags[0];
	endproperty
	a_watermark_set: assert property (p_watermark_set) // [RULE14]
		else $error("Watermark flag not set.");

	property p_irq_low;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		s_flag_on(7) and s_low_sel |=> o_irq_low;
	endproperty
	a_irq_low: assert property (p_irq_low) // [RULE20]
		else $error("Low interrupt missing.");

	// The bus answers with waitrequest low for a single cycle only.
	property p_wait_pulse;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && !avs_waitrequest) |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("Waitrequest low for more than one cycle.");

	property p_drive_high;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_tx_bit && !st_reg.pin_ctrl[5]) |=> !o_bus_transmit_pin_oe;
	endproperty
	a_drive_high: assert property (p_drive_high) // [RULE1]
		else $error("Recessive pin driven without drive-high.");

	property p_capture;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && st_reg.pin_ctrl[4]) |=> o_capture_compare_unit == $past(i_rx_msg);
	endproperty
	a_capture: assert property (p_capture) // [RULE2]
		else $error("Capture unit not fed by receive signal.");

	property p_invalid_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_events.invalid_msg) |=> st_reg.flags[7];
	endproperty
	a_invalid_set: assert property (p_invalid_set) // [RULE3]
		else $error("Invalid-message flag not set.");

	property p_wake_set;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_events.bus_wake) |=> st_reg.flags[6];
	endproperty
	a_wake_set: assert property (p_wake_set) // [RULE4]
		else $error("Wake flag not set.");

	property p_mode_zero_bits;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && i_mode == 2'h1) |=> st_reg.flags[0] == 1'b0 &&
			st_reg.flags[3:2] == 2'h0;
	endproperty
	a_mode_zero_bits: assert property (p_mode_zero_bits) // [RULE13]
		else $error("Forced-zero flag bits set in mode 1.");

	property p_irq_high;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		s_flag_on(7) and s_high_sel |=> o_irq_high;
	endproperty
	a_irq_high: assert property (p_irq_high) // [RULE20]
		else $error("High interrupt missing.");

	property p_irq_gate;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && (st_reg.flags & st_reg.enables) == 8'h00) |=>
			!o_irq_high && !o_irq_low;
	endproperty
	a_irq_gate: assert property (p_irq_gate) // [RULE15]
		else $error("Interrupt without enabled flag.");

	property p_flag_sticky;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_clk_en && st_reg.flags[5] && !avs_write && i_mode == 2'h0) |=>
			st_reg.flags[5];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // [RULE22]
		else $error("Flag dropped without a write.");

endmodule : cipc_core

// File: test/cipc_far_model.sv
/*
 * Far-side model: the bus wire level seen on the transmit pin.
 * Assumes the pin value and output enable of the core, one clock.
 */
module cipc_far_model (
	input wire logic i_ref_clk, // Clock.
	input wire logic i_pin, // Pin value from the core.
	input wire logic i_oe, // Pin output enable from the core.
	output logic o_wire // Resolved wire level.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_reg = 1'b0;
	// A released pin has no pull, so it shows a level that keeps changing.
	assign o_wire = i_oe ? i_pin : ~last_reg;
	always_ff @(posedge i_ref_clk) begin
		last_reg <= o_wire;
	end
endmodule : cipc_far_model

// File: test/testbench.sv
/*
 * Random test of the CAN interrupt and pin control core.
 * Assumes the core, its package and the far-side model.
 */
module testbench import cipc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, tx_bit = 1'b1, rx_msg = 1'b0;
	logic cpin = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [1:0] prx = 2'h0;
	logic [2:0] ptx = 3'h0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, rdw, seed = 32'h0000000A;
	logic wreq, irqh, irql, pin, oe, cap, wlvl;
	cipc_events_t ev = '0;
	int miscompares = 0, checked = 0, cyc = 0;
	always #25 clk = ~clk;
	cipc_core u_cipc_core (.i_ref_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1),
		.i_mode(mode), .i_events(ev), .i_per_tx_buffer_enables(ptx),
		.i_per_buffer_enables(prx), .i_tx_bit(tx_bit), .i_rx_msg(rx_msg),
		.i_capture_pin(cpin), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdw), .avs_waitrequest(wreq), .o_irq_high(irqh),
		.o_irq_low(irql), .o_bus_transmit_pin(pin),
		.o_bus_transmit_pin_oe(oe), .o_capture_compare_unit(cap));
	cipc_far_model u_cipc_far_model (.i_ref_clk(clk), .i_pin(pin),
		.i_oe(oe), .o_wire(wlvl));
	// ========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] exp_flags(int m, cipc_events_t e,
		logic [2:0] t, logic [1:0] r);
		if (m == 0)
			return {e.invalid_msg, e.bus_wake, e.bus_error, e.tx_done, e.rx_full};
		return {e.invalid_msg, e.bus_wake, e.bus_error, |(e.tx_done & t),
			2'h0, |(e.rx_full & r), m == 2 && e.watermark};
	endfunction : exp_flags
	task automatic chk(logic [31:0] e, logic [31:0] a);
		checked++;
		if (a !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t exp=%h act=%h", $time, e, a);
		end
	endtask : chk
	// Holds the request until waitrequest is sampled low.
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do @(posedge clk); while (wreq !== 1'b0);
		rdat = rdw;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			miscompares++;
			final_report();
		end
	end
	// ========================================
	// Main sequence
	initial begin
		logic [7:0] en, pr, k, f;
		logic [31:0] v;
		cipc_events_t e;
		int m;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, i == 4 ? 4'h2 : 4'(i * 4), 32'h0);
			chk(i == 3 ? 32'hFF : 32'h0, rdat);
		end
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			v[5:4] = 2'(i);
			bus(1'b1, 4'h0, v);
			bus(1'b0, 4'h0, 32'h0);
			chk(32'(v[7:0] & 8'h30), rdat);
			for (int t = 0; t < 2; t++) begin
				tx_bit <= t[0];
				rx_msg <= 1'(rnd());
				cpin <= 1'(rnd());
				repeat (4) @(posedge clk);
				chk(32'(t == 0 || v[5]), 32'(oe));
				if (oe === 1'b1)
					chk(32'(t), 32'(wlvl));
				chk(32'(v[4] ? rx_msg : cpin), 32'(cap));
			end
		end
		for (int n = 0; n < 30; n++) begin
			m = n < 3 ? n : rnd() % 3;
			e = n < 3 ? '1 : cipc_events_t'(9'(rnd()));
			en = 8'(rnd());
			pr = 8'(rnd());
			k = m == 0 ? 8'hFF : m == 1 ? 8'hF2 : 8'hF3;
			mode <= 2'(m);
			bus(1'b1, 4'h8, 32'(en));
			bus(1'b1, 4'hC, 32'(pr));
			bus(1'b1, 4'h4, 32'h0);
			@(posedge clk);
			ptx <= n < 3 ? 3'h7 : 3'(rnd());
			prx <= n < 3 ? 2'h3 : 2'(rnd());
			ev <= e;
			@(posedge clk);
			ev <= '0;
			repeat (3) @(posedge clk);
			f = exp_flags(m, e, ptx, prx) & k;
			chk(32'(|(f & en & k & pr)), 32'(irqh));
			chk(32'(|(f & en & k & ~pr)), 32'(irql));
			bus(1'b0, 4'h4, 32'h0);
			chk(32'(f[7:5]), 32'(rdat[7:5]));
			chk(32'(f[4:0]), 32'(rdat[4:0]));
			chk(32'(f[1:0]), 32'(rdat[1:0]));
			bus(1'b0, 4'h8, 32'h0);
			chk(32'(en & k), rdat);
			bus(1'b0, 4'hC, 32'h0);
			chk(32'(pr & k), rdat);
			bus(1'b1, 4'h4, 32'h0);
			bus(1'b0, 4'h4, 32'h0);
			chk(32'h0, rdat);
		end
		final_report();
	end
endmodule : testbench
